// File: rtl/pktz_conn.sv
// pktz_conn: connection open/close policy, inactivity timer and millisecond tick.
// assumes modem lines and events are synchronous to the clock.
`timescale 1ns/1ps
module pktz_conn #(
    parameter int MS_CYCLES = pktz_pkg::MS_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    pktz_conn_if.ctrl cif
);
    logic [15:0] div_q;
    logic tick_q;
    logic open_q;
    logic [16:0] idle_q;
    logic inact_hit;

    always_ff @(posedge clk) begin
        if (srst || div_q == 16'(MS_CYCLES - 1)) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        tick_q <= !srst && div_q == 16'(MS_CYCLES - 1);
    end
    assign cif.ms_tick = tick_q;

    // idle time counts serial traffic in both directions
    always_ff @(posedge clk) begin
        if (srst || cif.rx_evt || cif.tx_evt || !open_q) begin
            idle_q <= 17'h0_0000;
        end else if (tick_q && idle_q[16] == 1'b0) begin
            idle_q <= idle_q + 17'h0_0001;
        end
    end
    assign inact_hit = cif.inact_ms != 16'h0000 && idle_q >= {1'b0, cif.inact_ms};

    always_ff @(posedge clk) begin
        if (srst) begin
            open_q <= 1'b0;
        end else begin
            case (cif.policy)
                pktz_pkg::POL_STARTUP: open_q <= 1'b1;
                pktz_pkg::POL_ANY_NONE: open_q <= open_q || cif.rx_evt;
                pktz_pkg::POL_ANY_INACT: open_q <= cif.rx_evt || (open_q && !inact_hit);
                pktz_pkg::POL_DSR_OFF: open_q <= cif.dsr;
                pktz_pkg::POL_DSR_NONE: open_q <= open_q || cif.dsr;
                pktz_pkg::POL_DCD_OFF: open_q <= cif.dcd;
                pktz_pkg::POL_DCD_NONE: open_q <= open_q || cif.dcd;
                default: open_q <= 1'b0;
            endcase
        end
    end

    // all configured connections open and close together
    always_ff @(posedge clk) begin
        if (srst || !open_q) begin
            cif.conn_open <= 4'h0;
        end else begin
            cif.conn_open <= 4'((5'h02 << cif.max_conn) - 5'h01);
        end
    end

    property p_startup;
        @(posedge clk) disable iff (srst) cif.policy == pktz_pkg::POL_STARTUP |=> open_q ##1 cif.conn_open[0];
    endproperty
    a_startup: assert property (p_startup) else $error("startup policy did not open");

    property p_dsr_off;
        @(posedge clk) disable iff (srst)
            cif.policy == pktz_pkg::POL_DSR_OFF && !cif.dsr |=> !open_q ##1 cif.conn_open == 4'h0;
    endproperty
    a_dsr_off: assert property (p_dsr_off) else $error("dsr low did not close");

    property p_inact_zero;
        @(posedge clk) disable iff (srst)
            cif.policy == pktz_pkg::POL_ANY_INACT && open_q && cif.inact_ms == 16'h0000 |=> open_q;
    endproperty
    a_inact_zero: assert property (p_inact_zero) else $error("zero inactivity closed link");
endmodule : pktz_conn

// File: rtl/pktz_conn_if.sv
// pktz_conn_if: signals between the packetizer core and its connection control.
// assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pktz_conn_if;
    logic rx_evt;
    logic tx_evt;
    pktz_pkg::pktz_pol_t policy;
    logic [15:0] inact_ms;
    logic [1:0] max_conn;
    logic dsr;
    logic dcd;
    logic ms_tick;
    logic [3:0] conn_open;
    modport ctrl (input rx_evt, tx_evt, policy, inact_ms, max_conn, dsr, dcd, output ms_tick, conn_open);
    modport core (output rx_evt, tx_evt, policy, inact_ms, max_conn, dsr, dcd, input ms_tick, conn_open);
endinterface : pktz_conn_if

// File: rtl/pktz_pkg.sv
// pktz_pkg: shared constants and types of the serial packetizer.
// assumes one 40 MHz clock and a plain word-addressed register port.
package pktz_pkg;
    localparam int CLK_NS = 25;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_NS;
    localparam int BUF_DEPTH = 1024;
    localparam logic [10:0] BUF_FULL = 11'h400;
    localparam logic [6:0] DEST_MAX = 7'h40;
    localparam logic [7:0] BCAST_OCTET = 8'hFF;
    localparam logic [7:0] BCAST_HOSTS = 8'hFE;
    // register indices
    localparam logic [4:0] R_CTRL = 5'h00;
    localparam logic [4:0] R_DELIM = 5'h01;
    localparam logic [4:0] R_PKTLEN = 5'h02;
    localparam logic [4:0] R_GAP = 5'h03;
    localparam logic [4:0] R_INACT = 5'h04;
    localparam logic [4:0] R_STATUS = 5'h05;
    localparam logic [4:0] R_LPORT0 = 5'h06;
    localparam logic [4:0] R_LISTEN = 5'h0A;
    localparam logic [4:0] R_DBEG0 = 5'h0B;
    localparam logic [4:0] R_DCNT0 = 5'h0F;
    // control field positions
    localparam int C_D1EN = 0;
    localparam int C_D2EN = 1;
    localparam int C_PROC = 2;
    localparam int C_POL = 4;
    localparam int C_UDP = 7;
    localparam int C_MAXC = 8;
    // reset values
    localparam logic [15:0] LPORT_RST0 = 16'h1392;
    localparam logic [15:0] LISTEN_RST = 16'h0FA1;
    localparam logic [1:0] MAXC_RST = 2'h0;

    typedef enum logic [1:0] {PROC_NONE, PROC_PLUS1, PROC_PLUS2, PROC_STRIP} pktz_proc_t;
    typedef enum logic [2:0] {POL_STARTUP, POL_ANY_NONE, POL_ANY_INACT, POL_DSR_OFF,
                              POL_DSR_NONE, POL_DCD_OFF, POL_DCD_NONE} pktz_pol_t;
endpackage : pktz_pkg

// File: rtl/pktz_top.sv
// pktz_top: per-port serial packetizer with 1 KB buffer and connection control.
// assumes a byte-wide receiver handshake and network consumers with one ready per connection.
`timescale 1ns/1ps
module pktz_top #(
    parameter int MS_CYCLES = pktz_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // register port
    input wire logic [4:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // serial side
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    output logic RX_READY,
    input wire logic TX_ACT,
    input wire logic DSR,
    input wire logic DCD,
    // network side
    output logic PKT_VALID,
    output logic [7:0] PKT_DATA,
    output logic PKT_LAST,
    input wire logic [3:0] PKT_READY,
    output logic [3:0] CONN_OPEN
);
    logic [9:0] ctrl_q;
    logic [15:0] delim_q;
    logic [10:0] pktlen_q;
    logic [15:0] gap_set_q;
    logic [15:0] inact_q;
    logic [15:0] lport_q [4];
    logic [15:0] listen_q;
    logic [31:0] dbeg_q [4];
    logic [6:0] dcnt_q [4];
    logic [7:0] mem [pktz_pkg::BUF_DEPTH];
    logic [10:0] cnt_q;
    logic seen_d1_q;
    logic armed_q;
    logic [1:0] post_q;
    logic [16:0] gap_q;
    logic draining_q;
    logic [10:0] drain_len_q;
    logic [10:0] rd_idx_q;
    logic rx_ready_q;
    logic pkt_valid_q;
    logic [7:0] pkt_data_q;
    logic pkt_last_q;
    logic [31:0] rdata_q;
    logic d1_en, d2_en, rx_acc, hit, trig, strip_trig, gap_rel, start, all_rdy, adv, done, dest_err;
    pktz_pkg::pktz_proc_t proc;
    logic [10:0] cnt_nx;
    logic [10:0] ndelim;
    pktz_conn_if cif ();

    // effective host count of one datagram range
    function automatic logic [7:0] dest_eff(input logic [31:0] beg, input logic [6:0] cnt);
        if (beg[7:0] == pktz_pkg::BCAST_OCTET) begin
            dest_eff = pktz_pkg::BCAST_HOSTS;
        end else if (cnt > pktz_pkg::DEST_MAX) begin
            dest_eff = {1'b0, pktz_pkg::DEST_MAX};
        end else begin
            dest_eff = {1'b0, cnt};
        end
    endfunction : dest_eff

    assign d1_en = ctrl_q[pktz_pkg::C_D1EN];
    assign d2_en = ctrl_q[pktz_pkg::C_D2EN];
    assign proc = pktz_pkg::pktz_proc_t'(ctrl_q[pktz_pkg::C_PROC +: 2]);
    assign rx_acc = RX_VALID && rx_ready_q;
    assign cnt_nx = cnt_q + 11'h001;
    // a second delimiter only counts right after the first
    assign hit = d1_en && !armed_q && (d2_en ? (seen_d1_q && RX_DATA == delim_q[15:8])
                                             : RX_DATA == delim_q[7:0]);
    assign strip_trig = hit && proc == pktz_pkg::PROC_STRIP;
    assign ndelim = d2_en ? 11'h002 : 11'h001;
    assign trig = rx_acc && ((pktlen_q != 11'h000 && cnt_nx == pktlen_q)
                             || cnt_nx == pktz_pkg::BUF_FULL
                             || (hit && (proc == pktz_pkg::PROC_NONE || proc == pktz_pkg::PROC_STRIP))
                             || (armed_q && {1'b0, post_q} + 3'h1 == {1'b0, proc}));
    assign gap_rel = gap_set_q != 16'h0000 && gap_q > {1'b0, gap_set_q} && cnt_q != 11'h000
                     && !draining_q && !rx_acc;
    assign start = trig || gap_rel;
    assign all_rdy = (&(PKT_READY | ~cif.conn_open)) && (|cif.conn_open);
    assign adv = !pkt_valid_q || all_rdy;
    assign done = draining_q && adv && rd_idx_q == drain_len_q;
    assign dest_err = dcnt_q[0] == 7'h00 && dcnt_q[1] == 7'h00 && dcnt_q[2] == 7'h00
                      && dcnt_q[3] == 7'h00 && ctrl_q[pktz_pkg::C_UDP];

    assign cif.rx_evt = rx_acc;
    assign cif.tx_evt = TX_ACT;
    assign cif.policy = pktz_pkg::pktz_pol_t'(ctrl_q[pktz_pkg::C_POL +: 3]);
    assign cif.inact_ms = inact_q;
    assign cif.max_conn = ctrl_q[pktz_pkg::C_MAXC +: 2];
    assign cif.dsr = DSR;
    assign cif.dcd = DCD;

    pktz_conn #(.MS_CYCLES(MS_CYCLES)) u_conn (
        .clk(CLK),
        .srst(SRST),
        .cif(cif)
    );

    // configuration registers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ctrl_q <= {pktz_pkg::MAXC_RST, 8'h00};
            delim_q <= 16'h0000;
            pktlen_q <= 11'h000;
            gap_set_q <= 16'h0000;
            inact_q <= 16'h0000;
            listen_q <= pktz_pkg::LISTEN_RST;
            for (int i = 0; i < 4; i++) begin
                lport_q[i] <= pktz_pkg::LPORT_RST0 + 16'(i);
                dbeg_q[i] <= 32'h0000_0000;
                dcnt_q[i] <= 7'h00;
            end
        end else if (WR) begin
            if (ADDR == pktz_pkg::R_CTRL) begin
                ctrl_q <= WDATA[9:0];
            end else if (ADDR == pktz_pkg::R_DELIM) begin
                delim_q <= WDATA[15:0];
            end else if (ADDR == pktz_pkg::R_PKTLEN) begin
                pktlen_q <= (WDATA[10:0] > pktz_pkg::BUF_FULL) ? pktz_pkg::BUF_FULL : WDATA[10:0];
            end else if (ADDR == pktz_pkg::R_GAP) begin
                gap_set_q <= WDATA[15:0];
            end else if (ADDR == pktz_pkg::R_INACT) begin
                inact_q <= WDATA[15:0];
            end else if (ADDR >= pktz_pkg::R_LPORT0 && ADDR < pktz_pkg::R_LISTEN) begin
                lport_q[2'(ADDR - pktz_pkg::R_LPORT0)] <= WDATA[15:0];
            end else if (ADDR == pktz_pkg::R_LISTEN) begin
                listen_q <= WDATA[15:0];
            end else if (ADDR >= pktz_pkg::R_DBEG0 && ADDR < pktz_pkg::R_DCNT0) begin
                dbeg_q[2'(ADDR - pktz_pkg::R_DBEG0)] <= WDATA;
            end else if (ADDR >= pktz_pkg::R_DCNT0 && ADDR < pktz_pkg::R_DCNT0 + 5'h04) begin
                dcnt_q[2'(ADDR - pktz_pkg::R_DCNT0)] <= WDATA[6:0];
            end
        end
    end

    // read data stand one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge CLK) begin
        if (SRST || !RD) begin
            rdata_q <= 32'h0000_0000;
        end else if (ADDR == pktz_pkg::R_CTRL) begin
            rdata_q <= {22'h00_0000, ctrl_q};
        end else if (ADDR == pktz_pkg::R_DELIM) begin
            rdata_q <= {16'h0000, delim_q};
        end else if (ADDR == pktz_pkg::R_PKTLEN) begin
            rdata_q <= {21'h00_0000, pktlen_q};
        end else if (ADDR == pktz_pkg::R_GAP) begin
            rdata_q <= {16'h0000, gap_set_q};
        end else if (ADDR == pktz_pkg::R_INACT) begin
            rdata_q <= {16'h0000, inact_q};
        end else if (ADDR == pktz_pkg::R_STATUS) begin
            rdata_q <= {15'h0000, dest_err, draining_q, cif.conn_open, cnt_q};
        end else if (ADDR >= pktz_pkg::R_LPORT0 && ADDR < pktz_pkg::R_LISTEN) begin
            rdata_q <= {16'h0000, lport_q[2'(ADDR - pktz_pkg::R_LPORT0)]};
        end else if (ADDR == pktz_pkg::R_LISTEN) begin
            rdata_q <= {16'h0000, listen_q};
        end else if (ADDR >= pktz_pkg::R_DBEG0 && ADDR < pktz_pkg::R_DCNT0) begin
            rdata_q <= dbeg_q[2'(ADDR - pktz_pkg::R_DBEG0)];
        end else if (ADDR >= pktz_pkg::R_DCNT0 && ADDR < pktz_pkg::R_DCNT0 + 5'h04) begin
            rdata_q <= {24'h00_0000, dest_eff(dbeg_q[2'(ADDR - pktz_pkg::R_DCNT0)],
                                              dcnt_q[2'(ADDR - pktz_pkg::R_DCNT0)])};
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    always_ff @(posedge CLK) begin
        if (rx_acc) begin
            mem[cnt_q[9:0]] <= RX_DATA;
        end
    end

    // fill side: count, delimiter match and post-delimiter counter
    always_ff @(posedge CLK) begin
        if (SRST || done) begin
            cnt_q <= 11'h000;
            seen_d1_q <= 1'b0;
            armed_q <= 1'b0;
            post_q <= 2'h0;
        end else if (rx_acc) begin
            cnt_q <= cnt_nx;
            seen_d1_q <= d2_en && RX_DATA == delim_q[7:0];
            armed_q <= armed_q || (hit && (proc == pktz_pkg::PROC_PLUS1 || proc == pktz_pkg::PROC_PLUS2));
            post_q <= armed_q ? post_q + 2'h1 : 2'h0;
        end
    end

    // idle gap in milliseconds since the last received byte
    always_ff @(posedge CLK) begin
        if (SRST || done || rx_acc) begin
            gap_q <= 17'h0_0000;
        end else if (cif.ms_tick && cnt_q != 11'h000 && !gap_q[16]) begin
            gap_q <= gap_q + 17'h0_0001;
        end
    end

    // receiver is held off while a packet drains; the trigger byte itself is kept, except in strip mode where the delimiters are dropped
    always_ff @(posedge CLK) begin
        if (SRST) begin
            draining_q <= 1'b0;
            drain_len_q <= 11'h000;
            rx_ready_q <= 1'b0;
        end else begin
            rx_ready_q <= done || (!draining_q && !start);
            if (start) begin
                draining_q <= 1'b1;
                drain_len_q <= !rx_acc ? cnt_q : (strip_trig ? cnt_nx - ndelim : cnt_nx);
            end else if (done) begin
                draining_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST || done) begin
            rd_idx_q <= 11'h000;
            pkt_valid_q <= 1'b0;
            pkt_data_q <= 8'h00;
            pkt_last_q <= 1'b0;
        end else if (adv) begin
            if (draining_q && rd_idx_q < drain_len_q) begin
                pkt_valid_q <= 1'b1;
                pkt_data_q <= mem[rd_idx_q[9:0]];
                pkt_last_q <= rd_idx_q == drain_len_q - 11'h001;
                rd_idx_q <= rd_idx_q + 11'h001;
            end else begin
                pkt_valid_q <= 1'b0;
            end
        end
    end

    assign RDATA = rdata_q;
    assign RX_READY = rx_ready_q;
    assign PKT_VALID = pkt_valid_q;
    assign PKT_DATA = pkt_data_q;
    assign PKT_LAST = pkt_last_q;
    assign CONN_OPEN = cif.conn_open;

    property p_len;
        @(posedge CLK) disable iff (SRST) rx_acc && pktlen_q != 11'h000 && cnt_nx == pktlen_q
            |=> draining_q && drain_len_q == $past(cnt_nx) && !RX_READY;
    endproperty
    a_len: assert property (p_len) else $error("length limit did not release");

    property p_nolen;
        @(posedge CLK) disable iff (SRST) rx_acc && pktlen_q == 11'h000 && !d1_en && !armed_q
            && cnt_nx != pktz_pkg::BUF_FULL |=> !draining_q;
    endproperty
    a_nolen: assert property (p_nolen) else $error("release without cause");

    property p_full;
        @(posedge CLK) disable iff (SRST) rx_acc && cnt_nx == pktz_pkg::BUF_FULL |=> draining_q;
    endproperty
    a_full: assert property (p_full) else $error("full buffer not released");

    property p_delim;
        @(posedge CLK) disable iff (SRST) rx_acc && d1_en && !d2_en && !armed_q && proc == pktz_pkg::PROC_NONE
            && RX_DATA == delim_q[7:0] |=> draining_q ##1 !RX_READY;
    endproperty
    a_delim: assert property (p_delim) else $error("delimiter did not release");

    property p_strip;
        @(posedge CLK) disable iff (SRST) rx_acc && strip_trig && !draining_q
            |=> drain_len_q == $past(cnt_nx) - $past(ndelim);
    endproperty
    a_strip: assert property (p_strip) else $error("delimiter not stripped");

    property p_gap;
        @(posedge CLK) disable iff (SRST) gap_set_q != 16'h0000 && gap_q > {1'b0, gap_set_q}
            && cnt_q != 11'h000 && !draining_q && !rx_acc |=> draining_q && drain_len_q == $past(cnt_q);
    endproperty
    a_gap: assert property (p_gap) else $error("idle gap did not release");

    property p_clear;
        @(posedge CLK) disable iff (SRST) done |=> cnt_q == 11'h000 && gap_q == 17'h0_0000
            && !seen_d1_q && !armed_q && post_q == 2'h0 && RX_READY;
    endproperty
    a_clear: assert property (p_clear) else $error("state not cleared after release");

    property p_busy;
        @(posedge CLK) disable iff (SRST) draining_q |-> !RX_READY;
    endproperty
    a_busy: assert property (p_busy) else $error("receiver open while draining");

    property p_last;
        @(posedge CLK) disable iff (SRST) PKT_VALID && PKT_LAST && all_rdy
            |=> !PKT_VALID && cnt_q == 11'h000;
    endproperty
    a_last: assert property (p_last) else $error("stream did not stop after last byte");

    property p_hold;
        @(posedge CLK) disable iff (SRST) PKT_VALID && !all_rdy
            |=> PKT_VALID && $stable(PKT_DATA) && $stable(PKT_LAST);
    endproperty
    a_hold: assert property (p_hold) else $error("byte moved before every host was ready");

    property p_plus;
        @(posedge CLK) disable iff (SRST) rx_acc && armed_q && ((proc == pktz_pkg::PROC_PLUS1 && post_q == 2'h0)
            || (proc == pktz_pkg::PROC_PLUS2 && post_q == 2'h1)) |=> draining_q;
    endproperty
    a_plus: assert property (p_plus) else $error("post-delimiter bytes did not release");

    property p_gap_off;
        @(posedge CLK) disable iff (SRST) gap_set_q == 16'h0000 && !rx_acc && !draining_q
            |=> !draining_q;
    endproperty
    a_gap_off: assert property (p_gap_off) else $error("release with idle gap disabled");

    property p_first;
        @(posedge CLK) disable iff (SRST) start && !strip_trig
            |=> !PKT_VALID ##1 PKT_VALID;
    endproperty
    a_first: assert property (p_first) else $error("released packet did not start");
endmodule : pktz_top

// File: testbench/pktz_host_model.sv
// pktz_host_model: remote hosts behind the packet stream, one ready per connection.
// assumes the packetizer clock; ready of a closed connection is noise on purpose.
`timescale 1ns/1ps
module pktz_host_model (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // packet side
    input wire logic [3:0] conn_open,
    input wire logic slow,
    output logic [3:0] pkt_ready
);
    // slow hosts stall at random, so the group must wait on the slowest one
    always_ff @(posedge clk) begin
        if (srst) begin
            pkt_ready <= 4'h0;
        end else if (slow) begin
            pkt_ready <= 4'($urandom);
        end else begin
            pkt_ready <= conn_open | 4'($urandom);
        end
    end
endmodule : pktz_host_model

// File: testbench/test_serial_packetizer_conn_ctrl.sv
// test_serial_packetizer_conn_ctrl: self-checking bench for pktz_top.
// assumes pktz_host_model on the packet side and a 40 MHz clock.
`timescale 1ns/1ps
module test_serial_packetizer_conn_ctrl;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic rx_ready;
    logic tx_act = 1'b0;
    logic dsr = 1'b0;
    logic dcd = 1'b0;
    logic pkt_valid;
    logic [7:0] pkt_data;
    logic pkt_last;
    logic [3:0] pkt_ready;
    logic [3:0] conn_open;
    logic slow = 1'b0;
    logic [8:0] exp_q[$];
    logic [7:0] b[$];
    int fail_count = 0;
    int checks = 0;

    always #12.5 clk = ~clk;

    pktz_top #(.MS_CYCLES(8)) pktz_top_inst (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_READY(rx_ready), .TX_ACT(tx_act),
        .DSR(dsr), .DCD(dcd), .PKT_VALID(pkt_valid), .PKT_DATA(pkt_data), .PKT_LAST(pkt_last),
        .PKT_READY(pkt_ready), .CONN_OPEN(conn_open));
    pktz_host_model pktz_host_model_inst (.clk(clk), .srst(srst), .conn_open(conn_open), .slow(slow),
        .pkt_ready(pkt_ready));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    function automatic logic [31:0] ctl(input int d1, input int d2, input int pr, input int pol, input int mc);
        return 32'((d1 << pktz_pkg::C_D1EN) | (d2 << pktz_pkg::C_D2EN) | (pr << pktz_pkg::C_PROC)
            | (pol << pktz_pkg::C_POL) | (mc << pktz_pkg::C_MAXC));
    endfunction : ctl

    task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    // read data stand only in the cycle after the strobe, so sample at the edge closing it
    task automatic reg_rd(input logic [4:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        check(rdata, e);
    endtask : reg_rd

    // startup opens at the first edge after release; a dsr-off word with dsr low closes it before c lands
    task automatic restart(input logic [31:0] c, input int hold);
        @(posedge clk);
        srst <= 1'b1;
        repeat (hold) @(posedge clk);
        srst <= 1'b0;
        addr <= pktz_pkg::R_CTRL;
        wdata <= ctl(0, 0, 0, 3, 0);
        wr <= 1'b1;
        @(posedge clk);
        wdata <= c;
        @(posedge clk);
        wr <= 1'b0;
    endtask : restart

    task automatic fill(input int n);
        b.delete();
        repeat (n) b.push_back(8'($urandom_range(255, 16)));
    endtask : fill

    task automatic exp_pkt(input int n0, input int n);
        for (int i = n0; i < n0 + n; i++) begin
            exp_q.push_back({1'(i == n0 + n - 1), b[i]});
        end
    endtask : exp_pkt

    // caller is just past an edge; valid stays up across bytes so none is doubled, and no gap splits them
    task automatic send(input int n0, input int n);
        int k;
        for (int i = n0; i < n0 + n; i++) begin
            rx_valid <= 1'b1;
            rx_data <= b[i];
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (rx_ready !== 1'b1 && k < 4000);
            check(32'(k < 4000), 32'h0000_0001);
        end
        rx_valid <= 1'b0;
    endtask : send

    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        check(32'(exp_q.size()), 32'h0000_0000);
    endtask : drain

    // a byte leaves when every open host is ready; output with nothing noted is a mismatch
    always @(posedge clk) begin : monitor
        logic [31:0] e;
        if (!srst && pkt_valid === 1'b1 && (&(pkt_ready | ~conn_open)) && (|conn_open)) begin
            e = 32'h0000_0200;
            if (exp_q.size() != 0) e = 32'(exp_q.pop_front());
            check(32'({pkt_last, pkt_data}), e);
        end
    end

    initial begin : watchdog
        #(60000 * 25);
        fail_count++;
        print_verdict();
    end

    initial begin : main
        int r;
        r = $urandom(39);
        restart(32'h0000_0000, 16);
        repeat (3) @(posedge clk);
        check(32'(conn_open), 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            reg_rd(pktz_pkg::R_LPORT0 + 5'(i), 32'h0000_1392 + 32'(i));
        end
        reg_rd(pktz_pkg::R_LISTEN, 32'h0000_0FA1);
        reg_rd(pktz_pkg::R_PKTLEN, 32'h0000_0000);
        reg_rd(pktz_pkg::R_GAP, 32'h0000_0000);
        reg_rd(5'h1F, 32'h0000_0000);
        reg_wr(pktz_pkg::R_CTRL, ctl(0, 0, 0, 0, 3));
        repeat (3) @(posedge clk);
        check(32'(conn_open), 32'h0000_000F);
        slow <= 1'b1;
        reg_wr(pktz_pkg::R_PKTLEN, 32'h0000_07D0);
        reg_rd(pktz_pkg::R_PKTLEN, 32'h0000_0400);
        reg_wr(pktz_pkg::R_PKTLEN, 32'h0000_0005);
        fill(10);
        exp_pkt(0, 5);
        exp_pkt(5, 5);
        send(0, 10);
        drain();
        slow <= 1'b0;
        reg_wr(pktz_pkg::R_PKTLEN, 32'h0000_0000);
        reg_wr(pktz_pkg::R_DELIM, 32'h0000_0A0D);
        for (int p = 0; p < 4; p++) begin
            reg_wr(pktz_pkg::R_CTRL, ctl(1, 0, p, 0, 3));
            fill(3);
            b.push_back(8'h0D);
            repeat (p % 3) b.push_back(8'($urandom_range(255, 16)));
            exp_pkt(0, p == 3 ? 3 : 4 + p);
            send(0, b.size());
            drain();
        end
        // the second delimiter alone must not release; strip drops the pair
        reg_wr(pktz_pkg::R_CTRL, ctl(1, 1, 3, 0, 3));
        fill(1);
        b.push_back(8'h0A);
        b.push_back(8'h33);
        b.push_back(8'h0D);
        b.push_back(8'h0A);
        exp_pkt(0, 3);
        send(0, 5);
        drain();
        reg_wr(pktz_pkg::R_CTRL, ctl(1, 0, 0, 0, 3));
        fill(1024);
        exp_pkt(0, 1024);
        send(0, 1024);
        drain();
        // with gap off the bytes must sit until the gap is enabled
        reg_wr(pktz_pkg::R_CTRL, ctl(0, 0, 0, 0, 3));
        fill(3);
        send(0, 3);
        repeat (100) @(posedge clk);
        exp_pkt(0, 3);
        reg_wr(pktz_pkg::R_GAP, 32'h0000_0002);
        drain();
        fill(2);
        exp_pkt(0, 2);
        send(0, 2);
        repeat (16) @(posedge clk);
        check(32'(exp_q.size()), 32'h0000_0002);
        drain();
        restart(ctl(0, 0, 0, 1, 0), 2);
        repeat (4) @(posedge clk);
        check(32'(conn_open), 32'h0000_0000);
        fill(1);
        send(0, 1);
        repeat (4) @(posedge clk);
        check(32'(conn_open), 32'h0000_0001);
        restart(ctl(0, 0, 0, 2, 0), 2);
        send(0, 1);
        repeat (40) @(posedge clk);
        check(32'(conn_open), 32'h0000_0001);
        reg_wr(pktz_pkg::R_INACT, 32'h0000_0003);
        send(0, 1);
        repeat (12) @(posedge clk);
        tx_act <= 1'b1;
        @(posedge clk);
        tx_act <= 1'b0;
        // without the outgoing byte the link would already be down here
        repeat (14) @(posedge clk);
        check(32'(conn_open), 32'h0000_0001);
        repeat (40) @(posedge clk);
        check(32'(conn_open), 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            restart(ctl(0, 0, 0, 3 + k, 0), 2);
            repeat (4) @(posedge clk);
            check(32'(conn_open), 32'h0000_0000);
            if (k < 2) dsr <= 1'b1;
            else dcd <= 1'b1;
            repeat (4) @(posedge clk);
            check(32'(conn_open), 32'h0000_0001);
            dsr <= 1'b0;
            dcd <= 1'b0;
            repeat (4) @(posedge clk);
            check(32'(conn_open), 32'(k % 2));
        end
        reg_wr(pktz_pkg::R_DBEG0, 32'hC0A8_01FF);
        reg_wr(pktz_pkg::R_DCNT0, 32'h0000_000A);
        reg_rd(pktz_pkg::R_DCNT0, 32'h0000_00FE);
        reg_wr(pktz_pkg::R_DBEG0 + 5'h01, 32'h0A00_0005);
        reg_wr(pktz_pkg::R_DCNT0 + 5'h01, 32'h0000_0064);
        reg_rd(pktz_pkg::R_DCNT0 + 5'h01, 32'h0000_0040);
        print_verdict();
    end
endmodule : test_serial_packetizer_conn_ctrl
